/* hw/bsf_pkg.sv */
// shared constants, field layouts and types of the scan and fault control block
package bsf_pkg;
    // ****************************************************************
    // register word indices
    // ****************************************************************
    localparam logic [7:0] IDX_GLOBAL_OP = 8'h01;
    localparam logic [7:0] IDX_SCAN_OP   = 8'h02;
    localparam logic [7:0] IDX_CELL_OP   = 8'h03;
    localparam logic [7:0] IDX_PACKI_OP  = 8'h04;
    localparam logic [7:0] IDX_BAT_OP    = 8'h05;
    localparam logic [7:0] IDX_REG_OP    = 8'h06;
    localparam logic [7:0] IDX_ETAUX_OP  = 8'h07;
    localparam logic [7:0] IDX_FET_OP    = 8'h08;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h09;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h0a;
    localparam logic [7:0] IDX_STAT_FIRST = 8'h63;
    localparam logic [7:0] IDX_STAT_LAST  = 8'h69;
    localparam logic [7:0] IDX_CHG_REG    = 8'h67;
    localparam int         NUM_STAT       = 7;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int GLB_KICK_BIT  = 0;
    localparam int GLB_SEL_BIT   = 1;
    localparam int GLB_BUSY_BIT  = 2;
    localparam int SCAN_DLY_LSB  = 0;
    localparam int SCAN_DLY_W    = 3;
    localparam int SCAN_MODE_LSB = 4;
    localparam int CELL_WIPE_BIT = 7;
    localparam int CHG_PRES_BIT  = 5;
    localparam int IRQ_SCAN_BIT  = 0;
    localparam int IRQ_WIPE_BIT  = 1;
    localparam int IRQ_FAULT_BIT = 2;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ       = 10_000_000;
    localparam int SCAN_TIME_US = 100;
    localparam int SCAN_CYC     = (SCAN_TIME_US * (CLK_HZ / 1_000_000));
    localparam int DLY_UNIT_US  = 1000;
    localparam int DLY_UNIT_CYC = (DLY_UNIT_US * (CLK_HZ / 1_000_000));
    localparam int WIPE_CYC     = 4;

    typedef enum logic [1:0] {
        BSF_MODE_IDLE  = 2'b00,
        BSF_MODE_SCAN  = 2'b01,
        BSF_MODE_LOWP  = 2'b10,
        BSF_MODE_SHIP  = 2'b11
    } bsf_mode_t;

    typedef enum logic [1:0] {
        BSF_SEQ_IDLE = 2'b00,
        BSF_SEQ_WAIT = 2'b01,
        BSF_SEQ_RUN  = 2'b10,
        BSF_SEQ_WIPE = 2'b11
    } bsf_seq_t;

    // measurement selection handed to the analog side per scan
    typedef struct packed {
        logic       cell_voltage_on;
        logic [1:0] cell_voltage_averaging;
        logic       pack_current_on;
        logic [1:0] pack_current_averaging;
        logic       pack_voltage_on;
        logic       internal_temp_on;
        logic [1:0] misc_averaging;
        logic [1:0] misc_rate;
        logic       ext_temp_aux_on;
        logic [1:0] ext_temp_aux_averaging;
        logic       open_wire_on;
        logic [1:0] open_wire_rate;
    } bsf_meas_t;

    // avalon slave request bundle
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [9:0]  addr;
        logic [31:0] wdata;
    } bsf_bus_t;
endpackage

/* hw/bsf_delay_timer.sv */
// down counter that times the inter-scan delay and the scan itself
`timescale 1ns/1ns
module bsf_delay_timer
    import bsf_pkg::*;
(
    input  wire logic        ref_clk_in,   // block clock
    input  wire logic        rst_n_in,     // async reset, low
    input  wire logic        clk_en_in,    // freeze when low
    input  wire logic        load_in,      // load count
    input  wire logic [23:0] count_in,     // cycles to count
    output logic             done_out      // one-cycle pulse at zero
);
    typedef struct packed {
        logic [23:0] cnt;
        logic        run;
        logic        done;
    } bsf_tmr_t;

    bsf_tmr_t st;
    bsf_tmr_t next_st;

    // a load restarts the count even mid-run
    always_comb
    begin
        next_st      = st;
        next_st.done = 1'b0;
        if (load_in)
        begin
            next_st.cnt = count_in;
            next_st.run = 1'b1;
        end
        else if (st.run)
        begin
            if (st.cnt <= 24'h000001)
            begin
                next_st.run  = 1'b0;
                next_st.done = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt - 24'h000001;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            st <= '0;
        else if (clk_en_in)
            st <= next_st;
    end

    assign done_out = st.done;
endmodule

/* hw/bsf_top.sv */
// scan sequencing and fault wipe control with an avalon-mm register slave
// How it works
// - select=0, kick=0 write in scan mode enters continuous scan
// - select=1, kick=0 write stops continuous scan
// - one last scan after delay once stopped
// - delay field picks inter-scan wait
// - enables and averaging shape each scan
// - mode field accepts scan mode encoding
// - busy bit readable in global register
// - seven status registers readable separately
// - wipe clears 0x63..0x69, scan counter, keeps charger
// - wipe bit self-clears when done
// - live condition keeps its bit set
// - scan starts on kick rising edge
// - kick ignored outside scan mode
`timescale 1ns/1ns
module bsf_top
    import bsf_pkg::*;
(
    input  wire logic        ref_clk_in,          // 10 MHz clock
    input  wire logic        rst_n_in,            // async reset, low
    input  wire logic        clk_en_in,           // freeze when low
    input  wire logic [9:0]  avs_address_in,      // byte address
    input  wire logic        avs_read_in,         // read strobe
    input  wire logic        avs_write_in,        // write strobe
    input  wire logic [31:0] avs_writedata_in,    // write data
    input  wire logic [3:0]  avs_byteenable_in,   // byte lanes
    output logic [31:0]      avs_readdata_out,    // read data
    output logic             avs_waitrequest_out, // stall
    input  wire logic [55:0] fault_cond_in,       // live conditions, 8 per status reg
    input  wire logic        charger_present_in,  // charger pin
    output logic             scan_active_out,     // scan in progress
    output logic [18:0]      meas_sel_out,        // measurement selection
    output logic [7:0]       scan_count_out,      // completed scans counter
    output logic             irq_out              // level interrupt
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        kick;
        logic        sel;
        logic [2:0]  delay;
        bsf_mode_t   mode;
        logic        wipe;
        bsf_meas_t   meas;
        bsf_seq_t    seq;
        logic        last_pending;
        logic [7:0]  scan_cnt;
        logic [2:0]  wipe_cnt;
        logic [55:0] stat;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [1:0]  chg_sync;
        logic        irq;
        logic        active;
    } bsf_state_t;

    bsf_state_t  st;
    bsf_state_t  next_st;
    logic [55:0] cond_s1;
    logic [55:0] cond_s2;
    logic        tmr_load;
    logic [23:0] tmr_count;
    logic        tmr_done;
    bsf_bus_t    bus;

    // word index from a byte address
    function automatic logic [7:0] word_idx(input logic [9:0] a);
        word_idx = a[9:2];
    endfunction

    // delay cycles from the enumerated field, doubling per step
    function automatic logic [23:0] delay_cycles(input logic [2:0] code);
        delay_cycles = 24'(DLY_UNIT_CYC) << code;
    endfunction

    // ****************************************************************
    // input synchronisers and bus bundle
    // ****************************************************************
    // fault conditions come from the analog domain
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cond_s1 <= '0;
            cond_s2 <= '0;
        end
        else if (clk_en_in)
        begin
            cond_s1 <= fault_cond_in;
            cond_s2 <= cond_s1;
        end
    end

    assign bus = '{rd: avs_read_in, wr: avs_write_in, addr: avs_address_in,
                   wdata: avs_writedata_in};

    bsf_delay_timer u_tmr (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .clk_en_in  (clk_en_in),
        .load_in    (tmr_load),
        .count_in   (tmr_count),
        .done_out   (tmr_done)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic [7:0]  idx;
        logic [7:0]  wb;
        logic        req;
        logic [2:0]  ev;
        logic        start;
        logic [55:0] keep;

        idx       = word_idx(bus.addr);
        wb        = bus.wdata[7:0];
        req       = (bus.rd || bus.wr) && !st.ack;
        ev        = 3'b000;
        start     = 1'b0;
        keep      = '0;
        next_st   = st;
        tmr_load  = 1'b0;
        tmr_count = 24'(SCAN_CYC);
        next_st.ack      = req;
        next_st.chg_sync = {st.chg_sync[0], charger_present_in};

        // register writes; one wait state, ack marks the answer cycle
        if (req && bus.wr && avs_byteenable_in[0])
        begin
            unique case (idx)
                IDX_GLOBAL_OP:
                begin
                    // rising edge of kick in scan mode starts a single scan
                    if (wb[GLB_KICK_BIT] && !st.kick && st.mode == BSF_MODE_SCAN)
                        start = 1'b1;
                    if (!wb[GLB_KICK_BIT] && !wb[GLB_SEL_BIT])
                        next_st.sel = 1'b0;
                    if (!wb[GLB_KICK_BIT] && wb[GLB_SEL_BIT] && !st.sel)
                    begin
                        next_st.sel          = 1'b1;
                        next_st.last_pending = 1'b1;
                    end
                    next_st.kick = wb[GLB_KICK_BIT] && (st.mode == BSF_MODE_SCAN);
                end

                IDX_SCAN_OP:
                begin
                    next_st.delay = wb[SCAN_DLY_LSB +: SCAN_DLY_W];
                    next_st.mode  = bsf_mode_t'(wb[SCAN_MODE_LSB +: 2]);
                end

                IDX_CELL_OP:
                begin
                    next_st.meas.cell_voltage_on        = wb[0];
                    next_st.meas.cell_voltage_averaging = wb[2:1];
                    if (wb[CELL_WIPE_BIT])
                        next_st.wipe = 1'b1;
                end

                IDX_PACKI_OP:
                begin
                    next_st.meas.pack_current_on        = wb[0];
                    next_st.meas.pack_current_averaging = wb[2:1];
                    next_st.meas.open_wire_rate         = wb[4:3];
                end

                IDX_BAT_OP:
                begin
                    next_st.meas.pack_voltage_on  = wb[0];
                    next_st.meas.internal_temp_on = wb[1];
                    next_st.meas.misc_averaging   = wb[3:2];
                end

                IDX_REG_OP:   next_st.meas.misc_rate = wb[1:0];

                IDX_ETAUX_OP:
                begin
                    next_st.meas.ext_temp_aux_on        = wb[0];
                    next_st.meas.ext_temp_aux_averaging = wb[2:1];
                end

                IDX_FET_OP:   next_st.meas.open_wire_on = wb[0];

                IDX_IRQ_MASK: next_st.irq_mask = wb[2:0];

                default:      ;
            endcase
        end

        // read mux; unmapped words read zero
        next_st.rdata = '0;
        if (req && bus.rd)
        begin
            if (idx >= IDX_STAT_FIRST && idx <= IDX_STAT_LAST)
                next_st.rdata[7:0] = st.stat[8*(idx - IDX_STAT_FIRST) +: 8];
            else
            begin
                unique case (idx)
                    IDX_GLOBAL_OP: next_st.rdata[2:0] =
                        {st.seq != BSF_SEQ_IDLE, st.sel, st.kick};

                    IDX_SCAN_OP:   next_st.rdata[5:0] = {st.mode, 1'b0, st.delay};

                    IDX_CELL_OP:   next_st.rdata[7:0] = {st.wipe, 4'h0,
                        st.meas.cell_voltage_averaging, st.meas.cell_voltage_on};

                    IDX_PACKI_OP:  next_st.rdata[4:0] = {st.meas.open_wire_rate,
                        st.meas.pack_current_averaging, st.meas.pack_current_on};

                    IDX_BAT_OP:    next_st.rdata[3:0] = {st.meas.misc_averaging,
                        st.meas.internal_temp_on, st.meas.pack_voltage_on};

                    IDX_REG_OP:    next_st.rdata[1:0] = st.meas.misc_rate;

                    IDX_ETAUX_OP:  next_st.rdata[2:0] = {st.meas.ext_temp_aux_averaging,
                        st.meas.ext_temp_aux_on};

                    IDX_FET_OP:    next_st.rdata[0]   = st.meas.open_wire_on;

                    IDX_IRQ_STAT:  next_st.rdata[2:0] = st.irq_stat;

                    IDX_IRQ_MASK:  next_st.rdata[2:0] = st.irq_mask;

                    default:       next_st.rdata      = '0;
                endcase
            end
        end

        // scan sequencer
        unique case (st.seq)
            BSF_SEQ_IDLE:
            begin
                if (next_st.wipe)
                begin
                    next_st.seq      = BSF_SEQ_WIPE;
                    next_st.wipe_cnt = 3'(WIPE_CYC);
                end
                else if (start || (!next_st.sel && st.mode == BSF_MODE_SCAN
                                   && idx == IDX_GLOBAL_OP && req && bus.wr))
                begin
                    next_st.seq = BSF_SEQ_RUN;
                    tmr_load    = 1'b1;
                end
            end

            BSF_SEQ_RUN:
            begin
                // scans run with the measurement set in meas
                if (tmr_done)
                begin
                    next_st.scan_cnt = st.scan_cnt + 8'h01;
                    next_st.kick     = 1'b0;
                    ev[IRQ_SCAN_BIT] = 1'b1;
                    if ((!st.sel || st.last_pending) && st.mode == BSF_MODE_SCAN
                        && !st.kick)
                    begin
                        next_st.seq = BSF_SEQ_WAIT;
                        tmr_load    = 1'b1;
                        tmr_count   = delay_cycles(st.delay);
                    end
                    else
                        next_st.seq = BSF_SEQ_IDLE;
                end
            end

            BSF_SEQ_WAIT:
            begin
                // after a stop the pending delay still ends in one scan
                if (tmr_done)
                begin
                    next_st.seq = BSF_SEQ_RUN;
                    tmr_load    = 1'b1;
                    if (st.sel)
                        next_st.last_pending = 1'b0;
                end
            end

            BSF_SEQ_WIPE:
            begin
                if (st.wipe_cnt == 3'h0)
                begin
                    keep               = cond_s2;
                    keep[8*(IDX_CHG_REG - IDX_STAT_FIRST) + CHG_PRES_BIT] = 1'b1;
                    next_st.stat       = st.stat & keep;
                    next_st.scan_cnt   = 8'h00;
                    next_st.wipe       = 1'b0;
                    next_st.seq        = BSF_SEQ_IDLE;
                    ev[IRQ_WIPE_BIT]   = 1'b1;
                end
                else
                    next_st.wipe_cnt = st.wipe_cnt - 3'h1;
            end

            default: next_st.seq = BSF_SEQ_IDLE;
        endcase

        // conditions set sticky bits; charger bit follows its pin
        if (!(st.seq == BSF_SEQ_WIPE && st.wipe_cnt == 3'h0))
            next_st.stat = st.stat | cond_s2;
        else
            next_st.stat = next_st.stat | cond_s2;
        next_st.stat[8*(IDX_CHG_REG - IDX_STAT_FIRST) + CHG_PRES_BIT] = st.chg_sync[1];
        if (|(cond_s2 & ~st.stat))
            ev[IRQ_FAULT_BIT] = 1'b1;

        // status read clears, a new event in the same cycle wins
        if (req && bus.rd && idx == IDX_IRQ_STAT)
            next_st.irq_stat = ev;
        else
            next_st.irq_stat = st.irq_stat | ev;
        next_st.irq    = |(next_st.irq_stat & st.irq_mask);
        next_st.active = (next_st.seq == BSF_SEQ_RUN);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st      <= '0;
            st.sel  <= 1'b1; // not scanning after reset
            st.mode <= BSF_MODE_IDLE;
        end
        else if (clk_en_in)
            st <= next_st;
    end

    assign avs_readdata_out    = st.rdata;
    assign avs_waitrequest_out = !st.ack;
    assign scan_active_out     = st.active;
    assign meas_sel_out        = {1'b0, st.meas};
    assign scan_count_out      = st.scan_cnt;
    assign irq_out             = st.irq;
endmodule

/* verif/bsf_scan_monitor.sv */
// concurrent checks on bus answers, scan length, counter and selection
`timescale 1ns/1ns
module bsf_scan_monitor
    import bsf_pkg::*;
(
    input wire logic        ref_clk_in,          // clock
    input wire logic        rst_n_in,            // reset, low
    input wire logic        avs_read_in,         // read strobe
    input wire logic        avs_write_in,        // write strobe
    input wire logic [31:0] avs_readdata_out,    // read data
    input wire logic        avs_waitrequest_out, // stall
    input wire logic        scan_active_out,     // scan running
    input wire logic [18:0] meas_sel_out,        // selection
    input wire logic [7:0]  scan_count_out       // scan counter
);
    // ********
    // helper logic
    // ********
    logic [11:0] run_len;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // cycles of the running scan
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            run_len <= 12'h000;
        else if (scan_active_out)
            run_len <= run_len + 12'h001;
        else
            run_len <= 12'h000;
    end
    sequence bus_take;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence bus_answer;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    // ********
    // assertions
    // ********
    wait_state_a: assert property (bus_take |=> bus_answer)
        else $error("late bus answer");
    answer_cause_a: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
        else $error("bus answer without a request");
    rdata_idle_a: assert property (avs_waitrequest_out |-> avs_readdata_out == 32'h0)
        else $error("stale read data");
    rdata_upper_a: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
        else $error("upper read data set");
    scan_len_a: assert property ($fell(scan_active_out) |-> run_len >= SCAN_CYC - 1 && run_len <= SCAN_CYC + 1)
        else $error("scan length wrong");
    count_step_a: assert property ($changed(scan_count_out) |-> scan_count_out == $past(scan_count_out) + 8'h01 || scan_count_out == 8'h00)
        else $error("bad counter step");
    count_cause_a: assert property ($changed(scan_count_out) && scan_count_out != 8'h00 |-> $past(scan_active_out) || $past(scan_active_out, 2))
        else $error("count without scan");
    meas_cause_a: assert property ($changed(meas_sel_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
        else $error("selection moved unwritten");
endmodule

/* verif/bsf_host_model.sv */
// host side bus master reaching the scan block registers
`timescale 1ns/1ns
module bsf_host_model
    import bsf_pkg::*;
(
    input  wire logic        ref_clk_in, // clock
    input  wire logic [31:0] rdata_in,   // read data
    input  wire logic        wait_in,    // waitrequest
    output logic [9:0]       addr_out,   // byte address
    output logic             rd_out,     // read strobe
    output logic             wr_out,     // write strobe
    output logic [31:0]      wdata_out,  // write data
    output logic [3:0]       be_out      // byte lanes
);
    // idle bus from time zero
    initial
    begin
        addr_out = 10'h000;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
        be_out = 4'h0;
    end
    // one transfer, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        @(posedge ref_clk_in);
        addr_out <= {idx, 2'b00};
        rd_out <= !w;
        wr_out <= w;
        wdata_out <= {24'h0, d};
        be_out <= be;
        do @(posedge ref_clk_in); while (wait_in !== 1'b0);
        q = rdata_in;
        rd_out <= 1'b0;
        wr_out <= 1'b0;
    endtask
    // poll the wipe bit until it reads back zero, bounded
    task automatic wipe_poll(output int n);
        logic [31:0] q;
        n = 0;
        do
        begin
            xfer(1'b0, IDX_CELL_OP, 8'h00, 4'h1, q);
            n++;
        end
        while (q[CELL_WIPE_BIT] !== 1'b0 && n < 50);
    endtask
endmodule

/* verif/bsf_top_tb_top.sv */
// self-checking bench of the scan sequencing and fault wipe block
`timescale 1ns/1ns
module bsf_top_tb_top;
    import bsf_pkg::*;
    logic        ref_clk_in;
    logic        rst_n_in;
    logic [55:0] fault_cond;
    logic        chg;
    logic [9:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        scan_active;
    logic [18:0] meas_sel;
    logic [7:0]  scan_count;
    logic        irq;
    int          n_fail = 0;
    int          compares = 0;
    int          cyc = 0;
    // ********
    // clock, instances, timeout
    // ********
    initial
    begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    bsf_top uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .fault_cond_in(fault_cond),
        .charger_present_in(chg), .scan_active_out(scan_active),
        .meas_sel_out(meas_sel), .scan_count_out(scan_count), .irq_out(irq));
    bsf_host_model host (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .wait_in(waitreq),
        .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata), .be_out(be));
    // ceiling above the longest expected run
    always @(posedge ref_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_fail++;
            summarize();
        end
    end
    // ********
    // shared tasks
    // ********
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        host.xfer(1'b1, idx, d, 4'h1, q);
    endtask
    task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b0, idx, 8'h00, 4'h1, q);
        chk(nm, e, q);
    endtask
    task automatic wait_lvl(input logic lv, input int mx, output int n);
        n = 0;
        while (scan_active !== lv && n < mx)
        begin
            @(posedge ref_clk_in);
            n++;
        end
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_reset();
        rchk("global", IDX_GLOBAL_OP, 32'h02);
        rchk("scan op", IDX_SCAN_OP, 32'h00);
        wreg(8'h30, 8'h5a);
        rchk("unmapped", 8'h30, 32'h00);
        chk("irq", 32'h0, {31'h0, irq});
    endtask
    task automatic t_config();
        logic [31:0] q;
        bsf_meas_t   m;
        wreg(IDX_CELL_OP, 8'h07);
        wreg(IDX_FET_OP, 8'h01);
        host.xfer(1'b1, IDX_ETAUX_OP, 8'h07, 4'h0, q);
        repeat (3) @(posedge ref_clk_in);
        m = '0;
        m.cell_voltage_on = 1'b1;
        m.cell_voltage_averaging = 2'h3;
        m.open_wire_on = 1'b1;
        chk("meas sel", {14'h0, m}, {13'h0, meas_sel});
        rchk("lane off write", IDX_ETAUX_OP, 32'h00);
    endtask
    task automatic t_kick_idle();
        wreg(IDX_GLOBAL_OP, 8'h03);
        repeat (20) @(posedge ref_clk_in);
        chk("idle kick scan", 32'h0, {31'h0, scan_active});
        rchk("idle kick", IDX_GLOBAL_OP, 32'h02);
    endtask
    task automatic t_single();
        int n;
        wreg(IDX_IRQ_MASK, 8'h00);
        wreg(IDX_SCAN_OP, 8'h10);
        rchk("scan mode", IDX_SCAN_OP, 32'h10);
        wreg(IDX_GLOBAL_OP, 8'h03);
        wait_lvl(1'b1, 50, n);
        chk("kick start", 32'h1, {31'h0, scan_active});
        rchk("busy", IDX_GLOBAL_OP, 32'h07);
        wreg(IDX_GLOBAL_OP, 8'h03);
        wait_lvl(1'b0, 1100, n);
        repeat (2) @(posedge ref_clk_in);
        rchk("kick clear", IDX_GLOBAL_OP, 32'h02);
        chk("scan count", 32'h1, {24'h0, scan_count});
        chk("masked irq", 32'h0, {31'h0, irq});
        wait_lvl(1'b1, 1200, n);
        chk("held kick", 32'h0, {31'h0, scan_active});
        wreg(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge ref_clk_in);
        chk("irq up", 32'h1, {31'h0, irq});
        rchk("irq stat", IDX_IRQ_STAT, 32'h01);
        repeat (2) @(posedge ref_clk_in);
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask
    // continuous run with delay code c; quiet adds idle checks
    task automatic t_cont(input logic [2:0] c, input bit quiet);
        int n;
        int e;
        e = DLY_UNIT_CYC << c;
        wreg(IDX_SCAN_OP, {4'h1, 1'b0, c});
        wreg(IDX_GLOBAL_OP, 8'h00);
        wait_lvl(1'b1, e + 2000, n);
        wait_lvl(1'b0, 1100, n);
        if (quiet)
        begin
            wait_lvl(1'b1, e + 100, n);
            chk("scan gap", 32'h1, {31'h0, n >= e - 3 && n <= e + 3});
            wait_lvl(1'b0, 1100, n);
        end
        wreg(IDX_GLOBAL_OP, 8'h02);
        wait_lvl(1'b1, e + 100, n);
        chk("last scan", 32'h1, {31'h0, n + 3 >= e - 5 && n + 3 <= e + 5});
        wait_lvl(1'b0, 1100, n);
        if (quiet)
        begin
            wait_lvl(1'b1, e + SCAN_CYC + 100, n);
            chk("stopped", 32'h0, {31'h0, scan_active});
            rchk("stopped busy", IDX_GLOBAL_OP, 32'h02);
        end
    endtask
    task automatic t_wipe();
        int n;
        fault_cond <= 56'h07_06_05_04_03_02_01;
        chg <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        fault_cond <= 56'h01;
        repeat (6) @(posedge ref_clk_in);
        for (int k = 0; k < NUM_STAT; k++)
            rchk("status", IDX_STAT_FIRST + k, k + 1 + (k == 4 ? 8'h20 : 8'h00));
        wreg(IDX_IRQ_MASK, 8'h02);
        wreg(IDX_CELL_OP, 8'h87);
        host.wipe_poll(n);
        chk("wipe done", 32'h1, {31'h0, n < 50});
        chk("wipe irq", 32'h1, {31'h0, irq});
        for (int k = 0; k < NUM_STAT; k++)
            rchk("wiped", IDX_STAT_FIRST + k, k == 0 ? 8'h01 : (k == 4 ? 8'h20 : 8'h00));
        rchk("cell op", IDX_CELL_OP, 32'h07);
        chk("count wiped", 32'h0, {24'h0, scan_count});
        rchk("wipe event", IDX_IRQ_STAT, 32'h07);
        repeat (2) @(posedge ref_clk_in);
        chk("irq after read", 32'h0, {31'h0, irq});
    endtask
    // ********
    // main sequence
    // ********
    initial
    begin
        rst_n_in = 1'b0;
        fault_cond = 56'h0;
        chg = 1'b0;
        repeat (12) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_config();
        t_kick_idle();
        t_single();
        t_cont(3'h0, 1'b1);
        t_cont(3'h1, 1'b0);
        t_wipe();
        summarize();
    end
endmodule
bind bsf_top bsf_scan_monitor u_mon (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .scan_active_out(scan_active_out), .meas_sel_out(meas_sel_out),
    .scan_count_out(scan_count_out));
